// ### logic/pdm_pkg.sv
// Purpose: constants for processor debug-mode control
// Assumes: control word bit 0 is the least significant bit
// Notes:   vectors are offsets handed to the core
package pdm_pkg;
    // ------------------------------------------------------------
    // control word fields
    // ------------------------------------------------------------
    localparam int unsigned BIT_EXT_EN = 0;
    localparam int unsigned BIT_INT_EN = 1;
    localparam int unsigned RST_LO     = 2;
    localparam int unsigned RST_HI     = 3;
    localparam int unsigned BIT_TRAP   = 7;
    localparam int unsigned BIT_FREEZE = 31;
    localparam logic [31:0] CTL_RESET  = 32'h0000_0000;
    // ------------------------------------------------------------
    // reset kinds
    // ------------------------------------------------------------
    localparam logic [1:0]  RST_NONE   = 2'h0;
    localparam logic [1:0]  RST_PROC   = 2'h1;
    localparam logic [1:0]  RST_CHIP   = 2'h2;
    localparam logic [1:0]  RST_SYS    = 2'h3;
    // ------------------------------------------------------------
    // vectors
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_DEBUG  = 16'h2000;
    localparam logic [15:0] VEC_CRIT   = 16'h0100;
    localparam logic [15:0] VEC_EXT    = 16'h0500;
    // ------------------------------------------------------------
    // jtag commands
    // ------------------------------------------------------------
    localparam logic [2:0]  CMD_NONE   = 3'h0;
    localparam logic [2:0]  CMD_STOP   = 3'h1;
    localparam logic [2:0]  CMD_RUN    = 3'h2;
    localparam logic [2:0]  CMD_STEP   = 3'h3;
    localparam logic [2:0]  CMD_STUFF  = 3'h4;
    localparam logic [2:0]  CMD_FREEZE = 3'h5;
    localparam logic [2:0]  CMD_RESET  = 3'h6;
    // ------------------------------------------------------------
    // timer freeze modes and execution status
    // ------------------------------------------------------------
    localparam logic [1:0]  FRZ_RUN    = 2'h0;
    localparam logic [1:0]  FRZ_EVT    = 2'h1;
    localparam logic [1:0]  FRZ_FULL   = 2'h2;
    localparam logic [1:0]  EX_RUN     = 2'h0;
    localparam logic [1:0]  EX_STOP    = 2'h1;
    localparam logic [1:0]  EX_WAIT    = 2'h2;
    localparam int unsigned SYNC_W     = 39;
    typedef enum logic [2:0] {
        ST_RUN, ST_STOP, ST_STEP, ST_STUFF, ST_WAIT
    } pdm_state_t;
endpackage

// ### logic/pdm_sync.sv
// Purpose: two-stage synchroniser for pins from outside the clock
// Assumes: bits are independent levels or held around a sampling edge
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module pdm_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_clock,
    input  wire logic         i_reset,
    input  wire logic         i_clk_en,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            meta_r <= '0;
            sync_r <= '0;
        end else if (i_clk_en) begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule // pdm_sync

// ### logic/pdm_ctrl.sv
// Purpose: debug-mode control of a processor core
// Assumes: core signals share i_clock; jtag and halt pins do not
// Notes:   jtag command and data are sampled on the tck rising edge
// Behaviour
// - debug interrupt vectors to offset 0x2000
// - halt input stops execution until released
// - jtag stop command stops core, registers reachable
// - step command runs exactly one instruction
// - stuffed instructions skip privilege checks, keep stream
// - timers frozen fully, on events, or running
// - reset forced from jtag, control, or pins
// - jtag reports state, exceptions, last reset
// - wait and triggers only with both enables clear
// - debug interrupt needs internal and machine-state enables
// - external mode event stops core, bus continues
// - memory protection stays on in external mode
// - both modes: stop, irq pending, taken on restart
// - wait mode interrupts vector, return to stop
// - wait mode needs machine-state enable, both enables clear
// - trace always on; triggers only with enables clear
// - trace broadcast continuous, never stalls core
// - trap instructions become debug events when enabled
// - mode enables follow control word bits
// - bit 0 external enable, bit 1 internal
// - writing reset field forces that reset immediately
// - bit 31 freezes timers on debug event
`timescale 1ns/1ps
module pdm_ctrl (
    input  wire logic        i_clock,
    input  wire logic        i_reset,
    input  wire logic        i_clk_en,
    input  wire logic        i_jtag_tck,
    input  wire logic [2:0]  i_jtag_cmd,
    input  wire logic [31:0] i_jtag_data,
    input  wire logic        i_halt,
    input  wire logic [1:0]  i_ext_reset_kind,
    input  wire logic        i_ctl_wr,
    input  wire logic [31:0] i_ctl_wdata,
    input  wire logic        i_dbg_irq_en,
    input  wire logic        i_dbg_wait_en,
    input  wire logic        i_boundary,
    input  wire logic        i_debug_event,
    input  wire logic        i_trap_exec,
    input  wire logic        i_crit_irq,
    input  wire logic        i_ext_irq,
    input  wire logic        i_rfi,
    input  wire logic        i_stuff_ack,
    input  wire logic        i_sync_exc_pend,
    output logic [31:0]      o_ctl,
    output logic             o_stop,
    output logic             o_irq_take,
    output logic [15:0]      o_irq_vector,
    output logic             o_trap_to_debug,
    output logic             o_stuff_valid,
    output logic [31:0]      o_stuff_instr,
    output logic             o_stuff_no_priv,
    output logic             o_prot_active,
    output logic             o_timer_freeze,
    output logic             o_trace_enable,
    output logic             o_trace_trigger,
    output logic             o_wait_mode,
    output logic             o_reset_req,
    output logic [1:0]       o_reset_kind,
    output logic [1:0]       o_exec_state,
    output logic             o_exc_pend,
    output logic [1:0]       o_last_reset
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [pdm_pkg::SYNC_W-1:0] pins_s;
    logic                       tck_s;
    logic                       halt_s;
    logic [2:0]                 cmd_s;
    logic [31:0]                dat_s;
    logic [1:0]                 xrst_s;

    pdm_sync #(.W(pdm_pkg::SYNC_W)) u_sync (
        .i_clock  (i_clock),
        .i_reset  (i_reset),
        .i_clk_en (i_clk_en),
        .i_async  ({i_jtag_tck, i_halt, i_jtag_cmd,
                    i_jtag_data, i_ext_reset_kind}),
        .o_sync   (pins_s)
    );

    assign {tck_s, halt_s, cmd_s, dat_s, xrst_s} = pins_s;

    // ------------------------------------------------------------
    // jtag command capture on tck rising edge
    // ------------------------------------------------------------
    logic        tck_q_r;
    logic        jgo_r;
    logic [2:0]  jcmd_r;
    logic [31:0] jdat_r;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            tck_q_r <= 1'b0;
            jgo_r   <= 1'b0;
            jcmd_r  <= pdm_pkg::CMD_NONE;
            jdat_r  <= 32'h0000_0000;
        end else if (i_clk_en) begin
            tck_q_r <= tck_s;
            jgo_r   <= tck_s && !tck_q_r &&
                       (cmd_s != pdm_pkg::CMD_NONE);
            if (tck_s && !tck_q_r) begin
                jcmd_r <= cmd_s;
                jdat_r <= dat_s;
            end
        end
    end

    function automatic logic is_cmd(input logic [2:0] c);
        return jgo_r && (jcmd_r == c);
    endfunction

    // ------------------------------------------------------------
    // control word
    // ------------------------------------------------------------
    logic [31:0] ctl_r;
    logic        ext_en;
    logic        int_en;
    logic        dbg_evt;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            ctl_r <= pdm_pkg::CTL_RESET;
        end else if (i_clk_en && i_ctl_wr) begin
            ctl_r <= i_ctl_wdata;
        end
    end

    assign ext_en = ctl_r[pdm_pkg::BIT_EXT_EN];
    assign int_en = ctl_r[pdm_pkg::BIT_INT_EN];
    assign o_ctl = ctl_r;
    assign o_trap_to_debug = ctl_r[pdm_pkg::BIT_TRAP];
    assign dbg_evt = i_debug_event ||
                     (i_trap_exec && o_trap_to_debug);
    assign o_wait_mode = i_dbg_wait_en && !int_en && !ext_en;

    // ------------------------------------------------------------
    // stop sources
    // ------------------------------------------------------------
    pdm_pkg::pdm_state_t state_r;
    logic                jstop_r;
    logic                evstop_r;
    logic                pend_r;
    logic                stop_req;
    logic                exec_on;

    assign exec_on = (state_r == pdm_pkg::ST_RUN) ||
                     (state_r == pdm_pkg::ST_STEP);

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            jstop_r  <= 1'b0;
            evstop_r <= 1'b0;
        end else if (i_clk_en) begin
            if (is_cmd(pdm_pkg::CMD_RUN)) begin
                jstop_r  <= 1'b0;
                evstop_r <= 1'b0;
            end else if (is_cmd(pdm_pkg::CMD_STOP)) begin
                jstop_r <= 1'b1;
            end
            // event set wins over a run command in the same cycle
            if (exec_on && dbg_evt && ext_en) begin
                evstop_r <= 1'b1;
            end
        end
    end

    assign stop_req = halt_s || jstop_r || evstop_r;

    // ------------------------------------------------------------
    // execution state and interrupt dispatch
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_r      <= pdm_pkg::ST_RUN;
            pend_r       <= 1'b0;
            o_irq_take   <= 1'b0;
            o_irq_vector <= 16'h0000;
        end else if (i_clk_en) begin
            o_irq_take <= 1'b0;
            if (exec_on && dbg_evt && ext_en && int_en && i_dbg_irq_en) begin
                pend_r <= 1'b1;
            end
            unique case (state_r)
                pdm_pkg::ST_RUN: begin
                    if (dbg_evt && int_en && i_dbg_irq_en && !ext_en) begin
                        o_irq_take   <= 1'b1;
                        o_irq_vector <= pdm_pkg::VEC_DEBUG;
                    end
                    if (stop_req && i_boundary) begin
                        state_r <= pdm_pkg::ST_STOP;
                    end
                end
                pdm_pkg::ST_STOP: begin
                    if (!stop_req) begin
                        state_r <= pdm_pkg::ST_RUN;
                        if (pend_r) begin
                            pend_r       <= 1'b0;
                            o_irq_take   <= 1'b1;
                            o_irq_vector <= pdm_pkg::VEC_DEBUG;
                        end
                    end else if (o_wait_mode && i_crit_irq) begin
                        state_r      <= pdm_pkg::ST_WAIT;
                        o_irq_take   <= 1'b1;
                        o_irq_vector <= pdm_pkg::VEC_CRIT;
                    end else if (o_wait_mode && i_ext_irq) begin
                        state_r      <= pdm_pkg::ST_WAIT;
                        o_irq_take   <= 1'b1;
                        o_irq_vector <= pdm_pkg::VEC_EXT;
                    end else if (is_cmd(pdm_pkg::CMD_STEP)) begin
                        state_r <= pdm_pkg::ST_STEP;
                    end else if (is_cmd(pdm_pkg::CMD_STUFF)) begin
                        state_r <= pdm_pkg::ST_STUFF;
                    end
                end
                pdm_pkg::ST_STEP: begin
                    if (i_boundary) begin
                        state_r <= pdm_pkg::ST_STOP;
                    end
                end
                pdm_pkg::ST_STUFF: begin
                    if (i_stuff_ack) begin
                        state_r <= pdm_pkg::ST_STOP;
                    end
                end
                pdm_pkg::ST_WAIT: begin
                    if (i_rfi) begin
                        state_r <= pdm_pkg::ST_STOP;
                    end
                end
                default: begin
                    state_r <= pdm_pkg::ST_RUN;
                end
            endcase
        end
    end

    // core fetch gate; bus side is not gated
    assign o_stop = !exec_on && (state_r != pdm_pkg::ST_WAIT);

    // ------------------------------------------------------------
    // instruction stuffing
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_stuff_instr <= 32'h0000_0000;
        end else if (i_clk_en && is_cmd(pdm_pkg::CMD_STUFF) &&
                     state_r == pdm_pkg::ST_STOP) begin
            o_stuff_instr <= jdat_r;
        end
    end

    assign o_stuff_valid   = (state_r == pdm_pkg::ST_STUFF);
    assign o_stuff_no_priv = o_stuff_valid;
    assign o_prot_active   = 1'b1;

    // ------------------------------------------------------------
    // timer freeze
    // ------------------------------------------------------------
    logic [1:0] fmode_r;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            fmode_r        <= pdm_pkg::FRZ_RUN;
            o_timer_freeze <= 1'b0;
        end else if (i_clk_en) begin
            if (is_cmd(pdm_pkg::CMD_FREEZE)) begin
                fmode_r <= jdat_r[1:0];
            end
            o_timer_freeze <= (fmode_r == pdm_pkg::FRZ_FULL) ||
                ((fmode_r == pdm_pkg::FRZ_EVT ||
                  ctl_r[pdm_pkg::BIT_FREEZE]) &&
                 (o_stop || dbg_evt));
        end
    end

    // ------------------------------------------------------------
    // trace
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_trace_trigger <= 1'b0;
        end else if (i_clk_en) begin
            o_trace_trigger <= dbg_evt && !int_en && !ext_en;
        end
    end

    assign o_trace_enable = 1'b1;

    // ------------------------------------------------------------
    // forced reset
    // ------------------------------------------------------------
    logic [1:0] xrst_q_r;
    logic [1:0] wr_kind;

    assign wr_kind = i_ctl_wdata[pdm_pkg::RST_HI:pdm_pkg::RST_LO];

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            xrst_q_r     <= pdm_pkg::RST_NONE;
            o_reset_req  <= 1'b0;
            o_reset_kind <= pdm_pkg::RST_NONE;
            o_last_reset <= pdm_pkg::RST_NONE;
        end else if (i_clk_en) begin
            xrst_q_r    <= xrst_s;
            o_reset_req <= 1'b0;
            if (i_ctl_wr && wr_kind != pdm_pkg::RST_NONE) begin
                o_reset_req  <= 1'b1;
                o_reset_kind <= wr_kind;
                o_last_reset <= wr_kind;
            end else if (is_cmd(pdm_pkg::CMD_RESET) &&
                         jdat_r[1:0] != pdm_pkg::RST_NONE) begin
                o_reset_req  <= 1'b1;
                o_reset_kind <= jdat_r[1:0];
                o_last_reset <= jdat_r[1:0];
            end else if (xrst_s != pdm_pkg::RST_NONE &&
                         xrst_q_r == pdm_pkg::RST_NONE) begin
                o_reset_req  <= 1'b1;
                o_reset_kind <= xrst_s;
                o_last_reset <= xrst_s;
            end
        end
    end

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_exec_state <= pdm_pkg::EX_RUN;
            o_exc_pend   <= 1'b0;
        end else if (i_clk_en) begin
            o_exc_pend <= i_sync_exc_pend;
            if (state_r == pdm_pkg::ST_WAIT) begin
                o_exec_state <= pdm_pkg::EX_WAIT;
            end else if (o_stop) begin
                o_exec_state <= pdm_pkg::EX_STOP;
            end else begin
                o_exec_state <= pdm_pkg::EX_RUN;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_debug_vector: assert property (@(posedge i_clock)
        disable iff (i_reset)
        (i_clk_en && state_r == pdm_pkg::ST_RUN && dbg_evt && int_en &&
         i_dbg_irq_en && !ext_en) |=>
        (o_irq_take && o_irq_vector == pdm_pkg::VEC_DEBUG))
        else $error("debug interrupt not taken at debug vector");

    chk_stop_boundary: assert property (@(posedge i_clock)
        disable iff (i_reset)
        (i_clk_en && state_r == pdm_pkg::ST_RUN && stop_req &&
         i_boundary) |=> o_stop)
        else $error("stop request not honoured at boundary");

    chk_stop_cause: assert property (@(posedge i_clock)
        disable iff (i_reset)
        ($rose(o_stop) && $past(exec_on)) |->
        $past(i_boundary && stop_req))
        else $error("core stopped off boundary or without request");

    chk_step_one: assert property (@(posedge i_clock)
        disable iff (i_reset)
        (i_clk_en && state_r == pdm_pkg::ST_STEP && i_boundary) |=>
        (state_r == pdm_pkg::ST_STOP && o_stop))
        else $error("step ran past one instruction");

    chk_wait_crit: assert property (@(posedge i_clock)
        disable iff (i_reset)
        (i_clk_en && state_r == pdm_pkg::ST_STOP && stop_req &&
         o_wait_mode && i_crit_irq) |=>
        (o_irq_take && o_irq_vector == pdm_pkg::VEC_CRIT && !o_stop))
        else $error("critical interrupt not serviced while waiting");

    chk_rfi_return: assert property (@(posedge i_clock)
        disable iff (i_reset)
        (i_clk_en && state_r == pdm_pkg::ST_WAIT && i_rfi) |=>
        o_stop ##1 (o_exec_state == pdm_pkg::EX_STOP || !i_clk_en))
        else $error("return from interrupt did not restop");

    chk_trigger_gate: assert property (@(posedge i_clock)
        disable iff (i_reset)
        $rose(o_trace_trigger) |-> $past(!int_en && !ext_en))
        else $error("trace trigger while a debug mode is enabled");

    chk_reset_write: assert property (@(posedge i_clock)
        disable iff (i_reset)
        (i_clk_en && i_ctl_wr && wr_kind != pdm_pkg::RST_NONE) |=>
        (o_reset_req && o_reset_kind == $past(wr_kind)))
        else $error("reset field write did not force reset");

    chk_freeze_full: assert property (@(posedge i_clock)
        disable iff (i_reset)
        (i_clk_en && fmode_r == pdm_pkg::FRZ_FULL) |=> o_timer_freeze)
        else $error("timers not frozen in full freeze mode");
endmodule // pdm_ctrl

// ### tb/pdm_jtag_model.sv
// Purpose: external debugger model driving jtag pins and halt
// Assumes: one command per test clock frame, 160 ns frame
// Notes:   test clock stands low between frames
`timescale 1ns/1ps
module pdm_jtag_model (
    output logic        o_tck,
    output logic [2:0]  o_cmd,
    output logic [31:0] o_data,
    output logic        o_halt
);
    initial begin
        o_tck  = 1'b0;
        o_cmd  = 3'h0;
        o_data = 32'h0;
        o_halt = 1'b0;
    end
    // one framed command, lines scrambled once released
    task automatic send(input logic [2:0] c, input logic [31:0] d);
        o_cmd  = c;
        o_data = d;
        #40 o_tck = 1'b1;
        #80 o_tck = 1'b0;
        #40 o_cmd = ~c;
        o_data = ~d;
    endtask
    task automatic set_halt(input logic v);
        o_halt = v;
    endtask
endmodule // pdm_jtag_model

// ### tb/test_pdm_ctrl.sv
// Purpose: self-checking bench for debug-mode control
// Assumes: core side signals driven on the rising clock edge
// Notes:   debugger pins come from the partner model
`timescale 1ns/1ps
module test_pdm_ctrl;
    logic        clk, rst, wr, ien, wen, crit, ext, sep, tck, halt, ce;
    logic        stop, take, sv, snp, prot, frz, tren, trig, wm, rq, ep, ttd;
    logic [4:0]  p;
    logic [2:0]  cmd;
    logic [31:0] wdata, jd, ctl, si;
    logic [15:0] vec;
    logic [1:0]  rk, es, lr, xk;
    int          error_cnt, check_count;
    // ------------------------------------------------------------
    // design and partner
    // ------------------------------------------------------------
    pdm_ctrl i_pdm_ctrl (.i_clock(clk), .i_reset(rst), .i_clk_en(ce),
        .i_jtag_tck(tck), .i_jtag_cmd(cmd), .i_jtag_data(jd),
        .i_halt(halt), .i_ext_reset_kind(xk), .i_ctl_wr(wr),
        .i_ctl_wdata(wdata), .i_dbg_irq_en(ien), .i_dbg_wait_en(wen),
        .i_boundary(p[0]), .i_debug_event(p[1]), .i_trap_exec(p[4]),
        .i_crit_irq(crit), .i_ext_irq(ext), .i_rfi(p[3]),
        .i_stuff_ack(p[2]), .i_sync_exc_pend(sep), .o_ctl(ctl),
        .o_stop(stop), .o_irq_take(take), .o_irq_vector(vec),
        .o_trap_to_debug(ttd), .o_stuff_valid(sv), .o_stuff_instr(si),
        .o_stuff_no_priv(snp), .o_prot_active(prot),
        .o_timer_freeze(frz), .o_trace_enable(tren),
        .o_trace_trigger(trig), .o_wait_mode(wm), .o_reset_req(rq),
        .o_reset_kind(rk), .o_exec_state(es), .o_exc_pend(ep),
        .o_last_reset(lr));
    pdm_jtag_model i_pdm_jtag_model (.o_tck(tck), .o_cmd(cmd),
        .o_data(jd), .o_halt(halt));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic pls(input int i);
        @(posedge clk) p <= 5'(1 << i);
        @(posedge clk) p <= 5'h00;
        #1;
    endtask
    task automatic wctl(input logic [31:0] v);
        @(posedge clk) wr <= 1'b1;
        wdata <= v;
        @(posedge clk) wr <= 1'b0;
        #1;
    endtask
    task automatic do_reset;
        @(posedge clk) rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
    endtask
    task automatic js(input logic [2:0] c, input logic [31:0] d);
        i_pdm_jtag_model.send(c, d);
        repeat (2) @(posedge clk);
        #1;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_field;
        chk({es, stop, prot, tren}, 5'h03);
        @(posedge clk) sep <= 1'b1;
        repeat (3) @(posedge clk);
        chk(ep, 1);
        for (int k = 0; k < 4; k++) begin
            wctl(k << 2);
            chk(ctl, k << 2);
            chk(rq, k != 0);
            if (k != 0) chk(rk, k);
            chk(lr, k);
        end
    endtask
    task automatic t_event;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) ien <= (i == 2);
            wen <= 1'b1;
            wctl(i ? 32'h2 : 32'h0);
            chk(wm, i == 0);
            pls(1);
            chk(take, i == 2);
            chk(trig, i == 0);
            if (i == 2) chk(vec, pdm_pkg::VEC_DEBUG);
        end
    endtask
    task automatic t_jtag;
        js(pdm_pkg::CMD_STOP, 0);
        pls(0);
        chk(stop, 1);
        @(posedge clk) #1 chk(es, pdm_pkg::EX_STOP);
        js(pdm_pkg::CMD_STUFF, 32'hA5A5_0001);
        chk({sv, snp, stop}, 3'h7);
        chk(si, 32'hA5A5_0001);
        pls(2);
        @(posedge clk) #1 chk(sv, 0);
        js(pdm_pkg::CMD_STEP, 0);
        chk(stop, 0);
        pls(0);
        chk(stop, 1);
        js(pdm_pkg::CMD_FREEZE, 32'h2);
        chk(frz, 1);
        js(pdm_pkg::CMD_FREEZE, 32'h0);
        chk(frz, 0);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) crit <= (i == 0);
            ext <= (i == 1);
            @(posedge clk) crit <= 1'b0;
            ext <= 1'b0;
            #1 chk({take, stop}, 2'h2);
            chk(vec, i ? 16'h0500 : 16'h0100);
            pls(3);
            chk(es, pdm_pkg::EX_WAIT);
            chk(stop, 1);
        end
        js(pdm_pkg::CMD_RUN, 0);
        chk(stop, 0);
    endtask
    task automatic t_halt;
        i_pdm_jtag_model.set_halt(1'b1);
        repeat (4) @(posedge clk);
        pls(0);
        chk(stop, 1);
        i_pdm_jtag_model.set_halt(1'b0);
        repeat (6) @(posedge clk);
        #1 chk(stop, 0);
    endtask
    task automatic t_both;
        @(posedge clk) ien <= 1'b1;
        wctl(32'h3);
        pls(1);
        chk(take, 0);
        pls(0);
        chk(stop, 1);
        fork
            js(pdm_pkg::CMD_RUN, 0);
            begin
                repeat (60) begin
                    @(posedge clk) #1;
                    if (!stop) break;
                end
                chk({take, vec}, {1'b1, pdm_pkg::VEC_DEBUG});
            end
        join
    endtask
    task automatic t_extra;
        js(pdm_pkg::CMD_RESET, 32'h2);
        chk({rk, lr}, 4'hA);
        @(posedge clk) xk <= 2'h3;
        repeat (5) @(posedge clk);
        #1 chk({rk, lr}, 4'hF);
        @(posedge clk) xk <= 2'h0;
        wctl(32'h8000_0080);
        chk(ttd, 1);
        pls(4);
        chk({trig, frz}, 2'h3);
        @(posedge clk) #1 chk(frz, 0);
        @(posedge clk) ce <= 1'b0;
        pls(4);
        chk(trig, 0);
        @(posedge clk) ce <= 1'b1;
    endtask
    // ------------------------------------------------------------
    // clock, sequence, watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {wr, ien, wen, crit, ext, sep, p, wdata, xk} = '0;
        {rst, ce} = 2'h3;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_reset_field();
        t_event();
        do_reset();
        t_jtag();
        t_halt();
        t_both();
        t_extra();
        stop_test();
    end
    initial begin
        #200000;
        error_cnt++;
        stop_test();
    end
endmodule // test_pdm_ctrl
